/* core/mtc_ctrl.sv */
// Tape channel controller core: channel handshake and tape handler.
// Assumes one connected handler drives the shared status/read lines.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "mtc_defines.svh"
module mtc_ctrl (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Register port
	input  wire logic [1:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Channel and switch inputs
	input  wire logic [2:0]  eq_switch,
	input  wire logic [11:0] ch_data_in,
	input  wire logic        ch_parity_in,
	input  wire logic        ch_connect,
	input  wire logic        ch_function,
	input  wire logic        ch_data_req,
	input  wire logic        ch_read,
	input  wire logic        ch_write,
	input  wire logic        ch_master_clear,
	input  wire logic        ch_negate_conv,
	input  wire logic        ch_suppress_pack,
	// Channel outputs
	output logic      [11:0] ch_data_out,
	output logic             ch_parity_out,
	output logic             ch_data_oe,
	output logic             ch_reply,
	output logic             ch_reject,
	output logic             ch_end_of_record,
	output logic             ch_parity_error,
	output logic             ch_reverse_assembly,
	output logic      [10:0] ch_status,
	output logic      [7:0]  ch_interrupt,
	// Handler inputs
	input  wire logic [63:0] tp_unit_addr,
	input  wire logic [5:0]  tp_read_data,
	input  wire logic        tp_read_parity,
	input  wire logic        tp_read_strobe,
	input  wire logic        tp_write_enable,
	input  wire logic        tp_end_of_record,
	input  wire logic        tp_file_mark,
	input  wire logic        tp_busy,
	input  wire logic        tp_dens556,
	input  wire logic        tp_load_point,
	input  wire logic        tp_end_of_tape,
	input  wire logic        tp_ready,
	input  wire logic        tp_dens800,
	// Handler outputs
	output logic      [5:0]  tp_write_data,
	output logic             tp_write_parity,
	output logic             tp_write_strobe,
	output logic             tp_forward,
	output logic             search_file_mark,
	output logic             tp_set_hi_density,
	output logic             tp_set_lo_density,
	output logic             tp_write_sel,
	output logic             tp_read_sel,
	output logic             full_clear,
	output logic      [7:0]  tp_unit_sel
);
	import mtc_pkg::*;

	localparam logic [8:0] STROBE_CYC = 9'(`MTC_CYC(`MTC_STROBE_NS));
	localparam logic [8:0] STROBE_ALT_CYC = 9'(`MTC_CYC(`MTC_STROBE_ALT_NS));
	localparam logic [8:0] DPULSE_CYC = 9'(`MTC_CYC(`MTC_DPULSE_NS));

	mtc_sync_if sv ();
	mtc_in_t    s;
	mtc_in_t    r;

	// Character code swap for BCD mode, same in both directions
	function automatic logic [5:0] bcd_conv(input logic [5:0] c, input logic on);
		bcd_conv = on ? (c ^ `MTC_BCD_ZONE) : c;
	endfunction : bcd_conv

	// Odd parity bit over a channel word
	function automatic logic odd_bit(input logic [11:0] d);
		odd_bit = ~(^d);
	endfunction : odd_bit

	// Gather every async input into the synchroniser bank
	assign sv.raw = '{eq_switch: eq_switch, unit_addr: tp_unit_addr,
		rd_data: tp_read_data, rd_parity: tp_read_parity,
		rd_strobe: tp_read_strobe, write_enable: tp_write_enable,
		end_of_record: tp_end_of_record, file_mark: tp_file_mark,
		busy: tp_busy, dens556: tp_dens556, load_point: tp_load_point,
		end_of_tape: tp_end_of_tape, ready: tp_ready, dens800: tp_dens800,
		ch_data: ch_data_in, ch_parity: ch_parity_in, connect: ch_connect,
		function_req: ch_function, data_req: ch_data_req, read_op: ch_read,
		write_op: ch_write, master_clear: ch_master_clear,
		negate_conv: ch_negate_conv, suppress_pack: ch_suppress_pack};

	mtc_sync u_sync (
		.clk_sys (clk_sys),
		.sv      (sv)
	);
	assign s = sv.sync;
	assign r = sv.rise;

	// Control state
	mtc_state_t  state;
	logic        ctrl_conn;
	logic        unit_conn;
	logic        fmt_bcd;
	logic        perr;
	logic        strobe_alt;
	logic        rev_asm;
	logic        int_en;
	logic        searching;
	logic [8:0]  dcnt;
	logic        req_conn;
	// Write path
	logic [11:0] wr_word;
	logic [1:0]  wr_left;
	logic        wr_phase;
	logic [8:0]  wr_cnt;
	// Read path
	logic [5:0]  rd_upper;
	logic        rd_half;
	logic        rd_full;
	logic [11:0] rd_word;
	logic        eor_flag;
	logic        lost;
	logic        vperr;

	// Decode of the live channel word and handler match
	wire         clear_all  = rst | s.master_clear;
	wire         word_bad   = ~(^{s.ch_data, s.ch_parity});
	wire [2:0]   code_unit  = s.ch_data[2:0];
	wire [2:0]   code_equip = s.ch_data[11:9];
	wire         conv_on    = fmt_bcd & ~s.negate_conv;
	wire         wr_active  = (wr_left != 2'h0);
	wire         rw_busy    = s.read_op | s.write_op | wr_active | s.busy;
	wire [8:0]   strobe_len = strobe_alt ? STROBE_ALT_CYC : STROBE_CYC;
	wire [5:0]   wr_frame   = (wr_left == 2'h2) ? wr_word[11:6] : wr_word[5:0];
	wire [5:0]   rd_frame   = bcd_conv(s.rd_data, conv_on);
	wire         rd_vbad    = (^{s.rd_data, s.rd_parity}) == fmt_bcd;
	wire         rd_take    = r.rd_strobe & tp_read_sel;
	wire [11:0]  fn_code    = s.ch_data;
	logic [7:0]  unit_hit;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			unit_hit[i] = s.unit_addr[i][code_unit];
		end
	end
	wire [7:0]   unit_pick  = unit_hit & (~unit_hit + 8'h01);
	wire         fn_known   = (fn_code <= `MTC_FN_INT_RNB);

	// Channel request handshake: connect, function, data
	always_ff @(posedge clk_sys) begin
		if (clear_all) begin
			state            <= MTC_IDLE;
			ch_reply         <= 1'b0;
			ch_reject        <= 1'b0;
			ch_data_oe       <= 1'b0;
			ch_data_out      <= 12'h000;
			ch_parity_out    <= 1'b0;
			ch_end_of_record <= 1'b0;
			ctrl_conn        <= 1'b0;
			unit_conn        <= 1'b0;
			tp_unit_sel      <= 8'h00;
			fmt_bcd          <= 1'b0;
			perr             <= 1'b0;
			rev_asm          <= 1'b0;
			int_en           <= 1'b0;
			searching        <= 1'b0;
			dcnt             <= 9'h000;
			tp_set_hi_density <= 1'b0;
			tp_set_lo_density <= 1'b0;
			req_conn         <= 1'b0;
			wr_word          <= 12'h000;
			wr_left          <= 2'h0;
			rd_full          <= 1'b0;
			eor_flag         <= 1'b0;
		end else begin
			// Density pulse timer
			if (dcnt != 9'h000) begin
				dcnt <= dcnt - 9'h001;
			end else begin
				tp_set_hi_density <= 1'b0;
				tp_set_lo_density <= 1'b0;
			end
			// Search ends on file mark or record end
			if (r.file_mark | r.end_of_record) begin
				searching <= 1'b0;
			end
			// Frame writer frees a word slot
			if (wr_active && wr_phase && wr_cnt == 9'h001) begin
				wr_left <= wr_left - 2'h1;
			end
			// End of record seen while reading
			if (tp_read_sel && r.end_of_record) begin
				eor_flag <= 1'b1;
			end
			// Read frame assembly
			if (rd_take && (s.suppress_pack || rd_half)) begin
				rd_full <= 1'b1;
			end else if (tp_read_sel && r.end_of_record && rd_half) begin
				rd_full <= 1'b1;
			end
			case (state)
				MTC_IDLE: begin
					if (r.connect) begin
						req_conn <= 1'b1;
						perr     <= word_bad;
						if (word_bad || code_equip != s.eq_switch) begin
							ctrl_conn   <= 1'b0;
							unit_conn   <= 1'b0;
							tp_unit_sel <= 8'h00;
						end else if (rw_busy) begin
							ch_reject <= 1'b1;
							state     <= MTC_HOLD;
						end else begin
							ctrl_conn   <= 1'b1;
							unit_conn   <= (unit_pick != 8'h00);
							tp_unit_sel <= unit_pick;
							ch_reply    <= (unit_pick != 8'h00);
							ch_reject   <= (unit_pick == 8'h00);
							state       <= MTC_HOLD;
						end
					end else if (r.function_req && ctrl_conn) begin
						req_conn <= 1'b0;
						perr     <= word_bad;
						if (!word_bad) begin
							state <= MTC_HOLD;
							if (!unit_conn || !fn_known) begin
								ch_reject <= 1'b1;
							end else begin
								ch_reply <= 1'b1;
								case (fn_code)
									`MTC_FN_RELEASE, `MTC_FN_CLEAR: begin
										unit_conn   <= 1'b0;
										tp_unit_sel <= 8'h00;
										int_en      <= 1'b0;
										rev_asm     <= 1'b0;
									end
									`MTC_FN_BINARY: fmt_bcd <= 1'b0;
									`MTC_FN_BCD:    fmt_bcd <= 1'b1;
									`MTC_FN_HI_DENS: begin
										tp_set_hi_density <= 1'b1;
										tp_set_lo_density <= 1'b0;
										dcnt <= DPULSE_CYC;
									end
									`MTC_FN_LO_DENS: begin
										tp_set_lo_density <= 1'b1;
										tp_set_hi_density <= 1'b0;
										dcnt <= DPULSE_CYC;
									end
									`MTC_FN_SEARCH:  searching <= 1'b1;
									`MTC_FN_REV_ASM: rev_asm   <= 1'b1;
									default:         int_en    <= 1'b1;
								endcase
							end
						end
					end else if (s.data_req && unit_conn && s.write_op && !wr_active) begin
						// Sample only when the writer is free; channel waits
						perr     <= word_bad;
						wr_word  <= s.ch_data;
						wr_left  <= s.suppress_pack ? 2'h1 : 2'h2;
						ch_reply <= 1'b1;
						req_conn <= 1'b0;
						state    <= MTC_HOLD;
					end else if (s.data_req && unit_conn && s.read_op && rd_full) begin
						ch_data_out   <= rd_word;
						ch_parity_out <= odd_bit(rd_word);
						ch_data_oe    <= 1'b1;
						ch_reply      <= 1'b1;
						rd_full       <= rd_take & (s.suppress_pack | rd_half); // Fresh word wins
						state         <= MTC_RD_HOLD;
					end else if (s.data_req && unit_conn && s.read_op && eor_flag) begin
						ch_end_of_record <= 1'b1;
						eor_flag         <= tp_read_sel & r.end_of_record;
						state            <= MTC_RD_HOLD;
					end
				end
				MTC_HOLD: begin
					// Answer stands until its own request falls
					if (req_conn ? !s.connect : !(s.function_req | s.data_req)) begin
						ch_reply  <= 1'b0;
						ch_reject <= 1'b0;
						state     <= MTC_IDLE;
					end
				end
				MTC_RD_HOLD: begin
					if (!s.data_req) begin
						ch_reply         <= 1'b0;
						ch_end_of_record <= 1'b0;
						ch_data_oe       <= 1'b0;
						state            <= MTC_IDLE;
					end
				end
				default: state <= MTC_IDLE;
			endcase
		end
	end

	// Read assembly: upper frame first, then lower
	always_ff @(posedge clk_sys) begin
		if (clear_all) begin
			rd_upper <= 6'h00;
			rd_half  <= 1'b0;
			rd_word  <= 12'h000;
			lost     <= 1'b0;
			vperr    <= 1'b0;
		end else if (rd_take) begin
			lost  <= lost | rd_full; // Overrun flagged; the new word replaces the old
			vperr <= vperr | rd_vbad;
			if (s.suppress_pack) begin
				rd_word <= {6'h00, rd_frame};
			end else if (!rd_half) begin
				rd_upper <= rd_frame;
				rd_half  <= 1'b1;
			end else begin
				rd_word <= {rd_upper, rd_frame};
				rd_half <= 1'b0;
			end
		end else if (tp_read_sel && r.end_of_record && rd_half) begin
			rd_word <= {rd_upper, 6'h00}; // Odd frame flushed padded
			rd_half <= 1'b0;
		end else if (!s.read_op) begin
			rd_half <= 1'b0;
			vperr   <= vperr & ~r.write_op;
		end
	end

	// Frame writer: data and strobe set on one edge, strobe held strobe_len cycles
	always_ff @(posedge clk_sys) begin
		if (clear_all) begin
			wr_phase        <= 1'b0;
			wr_cnt          <= 9'h000;
			tp_write_data   <= 6'h00;
			tp_write_parity <= 1'b0;
			tp_write_strobe <= 1'b0;
		end else if (wr_active && !wr_phase) begin
			tp_write_data   <= bcd_conv(wr_frame, conv_on);
			tp_write_parity <= ~(^bcd_conv(wr_frame, conv_on)) ^ fmt_bcd;
			wr_phase        <= 1'b1;
			wr_cnt          <= strobe_len;
			tp_write_strobe <= 1'b1;
		end else if (wr_phase) begin
			wr_cnt <= wr_cnt - 9'h001;
			if (wr_cnt == 9'h001) begin
				tp_write_strobe <= 1'b0;
				wr_phase        <= 1'b0;
			end
		end
	end

	// Handler levels, status, interrupt and indicators
	always_ff @(posedge clk_sys) begin
		if (clear_all) begin
			full_clear          <= 1'b1;
			tp_write_sel        <= 1'b0;
			tp_read_sel         <= 1'b0;
			tp_forward          <= 1'b0;
			search_file_mark    <= 1'b0;
			ch_status           <= 11'h000;
			ch_interrupt        <= 8'h00;
			ch_parity_error     <= 1'b0;
			ch_reverse_assembly <= 1'b0;
		end else begin
			full_clear          <= 1'b0;
			tp_write_sel        <= unit_conn & (s.write_op | wr_active);
			tp_read_sel         <= unit_conn & s.read_op;
			search_file_mark    <= searching & unit_conn;
			tp_forward          <= unit_conn & (searching | s.read_op | wr_active);
			ch_parity_error     <= perr & unit_conn;
			ch_reverse_assembly <= rev_asm & unit_conn & s.read_op;
			ch_interrupt        <= (int_en && unit_conn && s.ready && !s.busy)
				? (8'h01 << s.eq_switch) : 8'h00;
			ch_status <= ctrl_conn ? {vperr, 1'b0, lost, s.dens800,
				s.write_enable, s.end_of_tape, s.load_point, s.file_mark,
				s.dens556, rw_busy, s.ready} : 11'h000;
		end
	end

	// Register port: control write, status read one cycle later
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			strobe_alt <= 1'b0;
			reg_rdata  <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == `MTC_REG_CTRL) begin
				strobe_alt <= reg_wdata[`MTC_CTRL_ALT_BIT];
			end
			if (reg_rd && reg_addr == `MTC_REG_CTRL) begin
				reg_rdata <= {7'h00, strobe_alt};
			end else if (reg_rd && reg_addr == `MTC_REG_STAT) begin
				reg_rdata <= {fmt_bcd, perr, int_en, unit_conn, ctrl_conn,
					wr_active, rd_full, state != MTC_IDLE};
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end
endmodule : mtc_ctrl
`default_nettype wire

/* core/mtc_defines.svh */
// Constants for the tape channel controller: codes, timing, offsets.
// Assumes inclusion by bare name from core files only.
`ifndef MTC_DEFINES_SVH
`define MTC_DEFINES_SVH
`define MTC_CLK_MHZ        40
`define MTC_STROBE_NS      4000
`define MTC_STROBE_ALT_NS  6000
`define MTC_DPULSE_NS      1000
`define MTC_CYC(ns)        (((ns) * `MTC_CLK_MHZ + 999) / 1000)
`define MTC_FN_RELEASE     12'h000
`define MTC_FN_BINARY      12'h001
`define MTC_FN_BCD         12'h002
`define MTC_FN_HI_DENS     12'h003
`define MTC_FN_LO_DENS     12'h004
`define MTC_FN_CLEAR       12'h005
`define MTC_FN_SEARCH      12'h006
`define MTC_FN_REV_ASM     12'h007
`define MTC_FN_INT_RNB     12'h008
`define MTC_REG_CTRL       2'h0
`define MTC_REG_STAT       2'h1
`define MTC_CTRL_ALT_BIT   0
`define MTC_BCD_ZONE       6'h10
`endif

/* core/mtc_pkg.sv */
// Types shared by the tape channel controller files.
// Assumes no other package is needed.
package mtc_pkg;
	// Every asynchronous input, channel and handler side
	typedef struct packed {
		logic [2:0]      eq_switch;
		logic [7:0][7:0] unit_addr;
		logic [5:0]      rd_data;
		logic            rd_parity;
		logic            rd_strobe;
		logic            write_enable;
		logic            end_of_record;
		logic            file_mark;
		logic            busy;
		logic            dens556;
		logic            load_point;
		logic            end_of_tape;
		logic            ready;
		logic            dens800;
		logic [11:0]     ch_data;
		logic            ch_parity;
		logic            connect;
		logic            function_req;
		logic            data_req;
		logic            read_op;
		logic            write_op;
		logic            master_clear;
		logic            negate_conv;
		logic            suppress_pack;
	} mtc_in_t;
	typedef enum logic [1:0] {MTC_IDLE, MTC_HOLD, MTC_RD_HOLD} mtc_state_t;
endpackage : mtc_pkg

/* core/mtc_sync_if.sv */
// Carrier between the synchroniser bank and the controller core.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface mtc_sync_if;
	mtc_pkg::mtc_in_t raw;
	mtc_pkg::mtc_in_t sync;
	mtc_pkg::mtc_in_t rise;
	modport syn (input raw, output sync, output rise);
	modport user (output raw, input sync, input rise);
endinterface : mtc_sync_if
`default_nettype wire

/* core/mtc_sync.sv */
// Two-flop synchroniser bank with rising-edge pulses.
// Assumes every input field is asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module mtc_sync (
	// Clock
	input wire logic clk_sys,
	// Raw in, clean out
	mtc_sync_if.syn  sv
);
	import mtc_pkg::*;
	mtc_in_t meta;
	mtc_in_t stage2;
	mtc_in_t stage3;
	// Edge found between stage2 and stage3, never from meta
	assign sv.sync = stage2;
	assign sv.rise = stage2 & ~stage3;
	// Plain chain, no reset needed on data path
	always_ff @(posedge clk_sys) begin
		meta   <= sv.raw;
		stage2 <= meta;
		stage3 <= stage2;
	end
endmodule : mtc_sync
`default_nettype wire

/* bench/mtc_checker.sv */
// Port-level assertions for the tape channel controller.
// Assumes binding onto mtc_ctrl, one clk_sys domain, rst synchronous.
`timescale 1ns/1ps
`default_nettype none
module mtc_checker (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst,
	// Channel side
	input wire logic        ch_connect,
	input wire logic        ch_function,
	input wire logic        ch_data_req,
	input wire logic        ch_reply,
	input wire logic        ch_reject,
	input wire logic        ch_parity_error,
	input wire logic [10:0] ch_status,
	input wire logic [7:0]  ch_interrupt,
	input wire logic [2:0]  eq_switch,
	// Handler side
	input wire logic [5:0]  tp_write_data,
	input wire logic        tp_write_parity,
	input wire logic        tp_write_strobe,
	input wire logic        tp_set_hi_density,
	input wire logic        tp_set_lo_density,
	input wire logic        full_clear,
	input wire logic [7:0]  tp_unit_sel
);
	logic [8:0] stb_len;
	wire        any_req = ch_connect | ch_function | ch_data_req;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Strobe width counter, cleared whenever the strobe is low
	always_ff @(posedge clk_sys) begin
		stb_len <= tp_write_strobe ? stb_len + 9'h001 : 9'h000;
	end
	// Reset itself is watched, so this one is never disabled
	property p_rst_quiet; disable iff (1'b0)
		rst |=> full_clear && ch_status == 11'h000 && tp_unit_sel == 8'h00; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("reset state wrong");
	property p_rel; $fell(rst) |-> full_clear ##1 !full_clear; endproperty
	a_rel: assert property (p_rel) else $error("full clear not one cycle past reset");
	property p_rep_excl; !(ch_reply && ch_reject); endproperty
	a_rep_excl: assert property (p_rep_excl) else $error("reply with reject");
	property p_rep_hold; ch_reply && any_req |=> ch_reply; endproperty
	a_rep_hold: assert property (p_rep_hold) else $error("reply dropped early");
	// Sync delay lets the answer linger three cycles; six is a safe bound
	property p_rep_drop; !any_req [*6] |-> !ch_reply && !ch_reject; endproperty
	a_rep_drop: assert property (p_rep_drop) else $error("answer without request");
	property p_stb_len;
		$fell(tp_write_strobe) |-> stb_len == 9'h0A0 || stb_len == 9'h0F0; endproperty
	a_stb_len: assert property (p_stb_len) else $error("write strobe width");
	property p_stb_data; tp_write_strobe && $past(tp_write_strobe)
		|-> $stable(tp_write_data) && $stable(tp_write_parity); endproperty
	a_stb_data: assert property (p_stb_data) else $error("frame moved under strobe");
	property p_dens;
		$rose(tp_set_hi_density) |-> ##40 tp_set_hi_density ##1 !tp_set_hi_density; endproperty
	a_dens: assert property (p_dens) else $error("density pulse width");
	property p_dens_excl; !(tp_set_hi_density && tp_set_lo_density); endproperty
	a_dens_excl: assert property (p_dens_excl) else $error("both densities");
	property p_perr;
		ch_parity_error |-> tp_unit_sel != 8'h00 || $past(tp_unit_sel) != 8'h00; endproperty
	a_perr: assert property (p_perr) else $error("parity error with no handler");
	property p_int; ch_interrupt != 8'h00 |-> ch_interrupt == (8'h01 << eq_switch); endproperty
	a_int: assert property (p_int) else $error("wrong interrupt line");
endmodule : mtc_checker
bind mtc_ctrl mtc_checker u_chk (.*);
`default_nettype wire

/* bench/mtc_tape_model.sv */
// Behavioural tape handler on one connector of the controller.
// Assumes the bench places unit_addr in that connector's address byte.
`timescale 1ns/1ps
`default_nettype none
module mtc_tape_model #(
	parameter int UNIT    = 2,
	parameter int BUSY_NS = 2000
) (
	// From the controller
	input  wire logic       full_clear,
	input  wire logic       tp_forward,
	input  wire logic       search_file_mark,
	input  wire logic       tp_set_hi_density,
	input  wire logic       tp_set_lo_density,
	input  wire logic [5:0] tp_write_data,
	input  wire logic       tp_write_parity,
	input  wire logic       tp_write_strobe,
	// To the controller
	output logic      [7:0] unit_addr,
	output logic      [5:0] tp_read_data,
	output logic            tp_read_parity,
	output logic            tp_read_strobe,
	output logic            tp_busy,
	output logic            tp_dens556,
	output logic            tp_end_of_record,
	output logic            tp_file_mark,
	output logic            tp_load_point,
	output logic            tp_write_enable
);
	logic [6:0] wq[$];
	// Ring in, at load point, stopped
	initial begin
		{tp_read_data, tp_read_parity, tp_read_strobe} = 8'h00;
		{tp_busy, tp_dens556, tp_end_of_record, tp_file_mark} = 4'h0;
		tp_load_point = 1'b1;
	end
	assign tp_write_enable = 1'b1;
	assign unit_addr = 8'h01 << UNIT;
	// Frames are taken as the strobe closes, so hold is tested too
	always @(negedge tp_write_strobe) wq.push_back({tp_write_parity, tp_write_data});
	// Motion, then a busy tail after it stops
	always @(posedge tp_forward) begin
		tp_busy = 1'b1;
		tp_load_point = 1'b0;
	end
	always @(negedge tp_forward) begin
		#(BUSY_NS);
		if (!tp_forward) tp_busy = 1'b0;
	end
	always @(posedge full_clear) tp_busy = 1'b0;
	// Density follows the select pulses
	always @(posedge tp_set_hi_density) tp_dens556 = 1'b1;
	always @(posedge tp_set_lo_density) tp_dens556 = 1'b0;
	// Search ends on a file mark, flagged as end of record
	always @(posedge search_file_mark) begin
		#3000;
		{tp_file_mark, tp_end_of_record} = 2'h3;
		#1000;
		{tp_file_mark, tp_end_of_record} = 2'h0;
	end
	// One frame per 200 ns link period; lines scramble once released
	task automatic send(input logic [5:0] d);
		tp_read_data = d;
		tp_read_parity = ~^d;
		#50 tp_read_strobe = 1'b1;
		#100 tp_read_strobe = 1'b0;
		#50 tp_read_data = ~d;
		tp_read_parity = ^d;
	endtask : send
endmodule : mtc_tape_model
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the tape channel controller.
// Assumes one handler model on connector 2 and a fixed equipment switch.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct packed {logic [11:0] code; logic [1:0] ans;} mtc_row_t;
	localparam logic [2:0] EQ = 3'h5;
	localparam logic [11:0] CONN = {EQ, 9'h002};
	logic clk_sys, rst, reg_wr, reg_rd, rp, rj;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, ch_interrupt, tp_unit_sel, tad;
	logic [2:0] eq_switch;
	logic [11:0] ch_data_in, ch_data_out;
	logic ch_parity_in, ch_connect, ch_function, ch_data_req, ch_read, ch_write;
	logic ch_master_clear, ch_negate_conv, ch_suppress_pack, ch_parity_out, ch_data_oe;
	logic ch_reply, ch_reject, ch_end_of_record, ch_parity_error, ch_reverse_assembly;
	logic [10:0] ch_status;
	logic [63:0] tp_unit_addr;
	logic [5:0] tp_read_data, tp_write_data;
	logic tp_read_parity, tp_read_strobe, tp_write_enable, tp_end_of_record, tp_file_mark;
	logic tp_busy, tp_dens556, tp_load_point, tp_end_of_tape, tp_ready, tp_dens800;
	logic tp_write_parity, tp_write_strobe, tp_forward, search_file_mark, tp_write_sel;
	logic tp_set_hi_density, tp_set_lo_density, tp_read_sel, full_clear;
	logic [15:0] v;
	int n_mismatch, n_checks;
	mtc_row_t rows [8] = '{'{12'h004, 2'h2}, '{12'h003, 2'h2}, '{12'h002, 2'h2},
		'{12'h001, 2'h2}, '{12'h007, 2'h2}, '{12'h009, 2'h1}, '{12'h0FF, 2'h1}, '{12'h008, 2'h2}};
	// Handler on connector 2; unused handler lines tied: ready high, end of tape and 800 density low
	assign tp_unit_addr = {40'h0, tad, 16'h0};
	assign {tp_ready, tp_end_of_tape, tp_dens800} = 3'h4;
	mtc_ctrl DUT (.*);
	mtc_tape_model #(.UNIT(2), .BUSY_NS(2000)) tape (.unit_addr(tad), .*);
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	function automatic logic [6:0] fr(input logic [5:0] d);
		return {~^d, d};
	endfunction : fr
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : step
	task automatic tend(input string nm);
		$display("test %s done", nm);
	endtask : tend
	// Register port: data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = {8'h00, reg_rdata};
	endtask : rd
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	// Channel request held until reply or reject, else timed out
	task automatic req(input int k, input logic [11:0] code, input logic bad);
		@(posedge clk_sys);
		ch_data_in <= code;
		ch_parity_in <= ~^code ^ bad;
		if (k == 0) ch_connect <= 1'b1;
		else if (k == 1) ch_function <= 1'b1;
		else ch_data_req <= 1'b1;
		for (int i = 0; i < 40 && ch_reply !== 1'b1 && ch_reject !== 1'b1; i++) step(1);
		{rp, rj} = {ch_reply, ch_reject};
		v = {ch_reverse_assembly, ch_end_of_record, ch_data_oe, ch_parity_out, ch_data_out};
		{ch_connect, ch_function, ch_data_req} <= 3'h0;
		step(8);
	endtask : req
	task automatic final_report;
		$display("checks %0d, mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	// Watchdog well past the few thousand cycles the tests need
	initial begin
		#1000000;
		n_mismatch++;
		final_report();
	end
	initial begin
		rst = 1'b1;
		{reg_addr, reg_wdata, reg_wr, reg_rd, eq_switch} = {12'h000, EQ};
		{ch_data_in, ch_parity_in, ch_connect, ch_function, ch_data_req} = 16'h0000;
		{ch_read, ch_write, ch_master_clear, ch_negate_conv, ch_suppress_pack} = 5'h00;
		step(3);
		chk("reset", {full_clear, tp_unit_sel, ch_status[6:0]}, 16'h8000);
		rst <= 1'b0;
		rd(2'h3);
		chk("unmapped", v, 16'h0000);
		rd(2'h1);
		chk("bcd at reset", v[7], 1'b0);
		wr(2'h0, 8'h01);
		rd(2'h0);
		chk("ctrl", v, 16'h0001);
		tape.wq.delete();
		tend("reset and registers");
		req(0, CONN, 1'b0);
		chk("connect", {rp, rj, tp_unit_sel, ch_status[0]}, 16'h0409);
		foreach (rows[i]) begin
			req(1, rows[i].code, 1'b0);
			chk("fn answer", {rp, rj}, rows[i].ans);
		end
		chk("density", tp_dens556, 1'b1);
		chk("interrupt", ch_interrupt, 8'h01 << EQ);
		req(1, 12'h001, 1'b1);
		chk("bad parity", {rp, rj, ch_parity_error}, 16'h0001);
		tend("functions");
		ch_write <= 1'b1;
		req(2, 12'hB4D, 1'b0);
		for (int i = 0; i < 1000 && tape.wq.size() < 2; i++) step(1);
		chk("frames", {tape.wq[0], tape.wq[1]}, {fr(6'h2D), fr(6'h0D)});
		ch_suppress_pack <= 1'b1;
		req(2, 12'hFC3, 1'b0);
		for (int i = 0; i < 1000 && tape.wq.size() < 3; i++) step(1);
		step(20);
		chk("one frame", {tp_write_strobe, 6'(tape.wq.size()), tape.wq[2]}, {7'h03, fr(6'h03)});
		{ch_write, ch_suppress_pack} <= 2'h0;
		tend("write");
		ch_read <= 1'b1;
		step(4);
		tape.send(6'h2A);
		tape.send(6'h15);
		req(2, 12'h000, 1'b0);
		chk("read word", v, {3'h5, ~^12'hA95, 12'hA95});
		ch_suppress_pack <= 1'b1;
		step(4);
		tape.send(6'h2B);
		req(2, 12'h000, 1'b0);
		chk("packed off", v[11:0], 12'h02B);
		{ch_read, ch_suppress_pack} <= 2'h0;
		tend("read");
		req(1, 12'h006, 1'b0);
		chk("search on", search_file_mark, 1'b1);
		step(300);
		chk("search off", search_file_mark, 1'b0);
		req(1, 12'h005, 1'b0);
		chk("clear", {rp, rj, tp_unit_sel}, 16'h0200);
		req(1, 12'h000, 1'b0);
		chk("release refused", {rp, rj}, 2'h1);
		rd(2'h1);
		chk("still connected", v[4:3], 2'h1);
		tend("clear");
		req(0, CONN, 1'b0);
		req(1, 12'h002, 1'b0);
		{ch_write, ch_suppress_pack} <= 2'h3;
		req(2, 12'h003, 1'b0);
		for (int i = 0; i < 1000 && tape.wq.size() < 4; i++) step(1);
		ch_negate_conv <= 1'b1;
		req(2, 12'h003, 1'b0);
		for (int i = 0; i < 1000 && tape.wq.size() < 5; i++) step(1);
		chk("bcd frames", {tape.wq[3], tape.wq[4]}, {1'b1, 6'h13, 1'b0, 6'h03});
		{ch_write, ch_suppress_pack, ch_negate_conv} <= 3'h0;
		ch_master_clear <= 1'b1;
		step(5);
		chk("mc clear", full_clear, 1'b1);
		ch_master_clear <= 1'b0;
		step(5);
		rd(2'h1);
		chk("after mc", {v[7], tp_unit_sel, ch_status[6:0]}, 16'h0000);
		tend("master clear");
		final_report();
	end
endmodule : testbench
`default_nettype wire
